// *** hw/fpp_pkg.sv ***
// package: constants and types of the flash parallel programming port
package fpp_pkg;
   localparam int unsigned ADDR_W     = 17;
   localparam int unsigned DATA_W     = 8;
   localparam logic [7:0]  CMD_READ   = 8'h00;
   localparam logic [7:0]  CMD_PROG   = 8'h40;
   localparam logic [7:0]  CMD_PVFY   = 8'hc0;
   localparam logic [7:0]  CMD_ERASE  = 8'h20;
   localparam logic [7:0]  CMD_EVFY   = 8'ha0;
   localparam logic [7:0]  CMD_RESET  = 8'hff;
   localparam logic [7:0]  IDLE_DATA  = 8'hff;
   localparam logic [16:0] ADDR_RESET = 17'h00000;
   // boot area erase block size in bytes (3.5 K)
   localparam int unsigned BOOT_BLOCK_BYTES = 3584;

   typedef enum logic [1:0] {
      FPP_BUS_STANDBY,
      FPP_BUS_OUT_DIS,
      FPP_BUS_READ,
      FPP_BUS_WRITE
   } fpp_bus_e;

   typedef enum logic [3:0] {
      FPP_OP_NONE,
      FPP_OP_READ,
      FPP_OP_PROG,
      FPP_OP_PVFY,
      FPP_OP_ERASE,
      FPP_OP_EVFY,
      FPP_OP_RESET
   } fpp_op_e;
endpackage

// *** hw/fpp_cmd_if.sv ***
// interface: captured write strobes and decoded commands between port modules
interface fpp_cmd_if;
   logic                        wr_valid;
   logic [fpp_pkg::ADDR_W-1:0]  wr_addr;
   logic [fpp_pkg::DATA_W-1:0]  wr_data;
   logic                        array_sel;
   fpp_pkg::fpp_op_e            op;
   logic                        op_valid;
   logic [fpp_pkg::ADDR_W-1:0]  op_addr;
   logic [fpp_pkg::DATA_W-1:0]  op_data;
   modport capture (output wr_valid, output wr_addr, output wr_data);
   modport decode  (input wr_valid, input wr_addr, input wr_data,
                    output array_sel, output op, output op_valid,
                    output op_addr, output op_data);
   modport user    (input array_sel, input op, input op_valid,
                    input op_addr, input op_data);
endinterface

// *** hw/fpp_cmd_decode.sv ***
// module: software command byte sequencer of the parallel port
module fpp_cmd_decode (
   input  wire logic clock,
   input  wire logic reset,
   fpp_cmd_if.decode cmd
);
   typedef enum logic [2:0] {
      FPP_C_IDLE,
      FPP_C_PROG,
      FPP_C_ERASE,
      FPP_C_RESET,
      FPP_C_VERIFY
   } fpp_cstate_e;

   fpp_cstate_e cstate_q;
   logic        array_sel_q;

   assign cmd.array_sel = array_sel_q;

   // sequence of command bytes; only writes change it
   always_ff @(posedge clock) begin
      if (reset) begin
         cstate_q <= FPP_C_IDLE;
      end else if (cmd.wr_valid) begin
         unique case (cstate_q)
            FPP_C_PROG:  cstate_q <= FPP_C_IDLE;
            FPP_C_ERASE: cstate_q <= FPP_C_IDLE;
            FPP_C_RESET: cstate_q <= FPP_C_IDLE;
            FPP_C_IDLE, FPP_C_VERIFY: begin
               unique case (cmd.wr_data)
                  fpp_pkg::CMD_PROG:  cstate_q <= FPP_C_PROG;
                  fpp_pkg::CMD_ERASE: cstate_q <= FPP_C_ERASE;
                  fpp_pkg::CMD_RESET: cstate_q <= FPP_C_RESET;
                  fpp_pkg::CMD_PVFY:  cstate_q <= FPP_C_VERIFY;
                  fpp_pkg::CMD_EVFY:  cstate_q <= FPP_C_VERIFY;
                  default:            cstate_q <= FPP_C_IDLE;
               endcase
            end
            default: cstate_q <= FPP_C_IDLE;
         endcase
      end
   end

   // array data is visible after reset, read, reset-pair or verify commands
   always_ff @(posedge clock) begin
      if (reset) begin
         array_sel_q <= 1'b1;
      end else if (cmd.wr_valid) begin
         if (cstate_q == FPP_C_RESET && cmd.wr_data == fpp_pkg::CMD_RESET) begin
            array_sel_q <= 1'b1;
         end else if (cstate_q == FPP_C_IDLE || cstate_q == FPP_C_VERIFY) begin
            array_sel_q <= (cmd.wr_data == fpp_pkg::CMD_READ) ||
                           (cmd.wr_data == fpp_pkg::CMD_PVFY) ||
                           (cmd.wr_data == fpp_pkg::CMD_EVFY);
         end else begin
            array_sel_q <= 1'b0;
         end
      end
   end

   // one-cycle operation request toward the flash controller
   always_ff @(posedge clock) begin
      if (reset) begin
         cmd.op       <= fpp_pkg::FPP_OP_NONE;
         cmd.op_valid <= 1'b0;
         cmd.op_addr  <= fpp_pkg::ADDR_RESET;
         cmd.op_data  <= '0;
      end else begin
         cmd.op_valid <= 1'b0;
         if (cmd.wr_valid) begin
            cmd.op_addr <= cmd.wr_addr;
            cmd.op_data <= cmd.wr_data;
            unique case (cstate_q)
               FPP_C_PROG: begin
                  cmd.op       <= fpp_pkg::FPP_OP_PROG;
                  cmd.op_valid <= 1'b1;
               end
               FPP_C_ERASE: begin
                  cmd.op       <= fpp_pkg::FPP_OP_ERASE;
                  cmd.op_valid <= (cmd.wr_data == fpp_pkg::CMD_ERASE);
               end
               FPP_C_RESET: begin
                  cmd.op       <= fpp_pkg::FPP_OP_RESET;
                  cmd.op_valid <= (cmd.wr_data == fpp_pkg::CMD_RESET);
               end
               default: begin
                  cmd.op_valid <= (cmd.wr_data == fpp_pkg::CMD_READ) ||
                                  (cmd.wr_data == fpp_pkg::CMD_PVFY) ||
                                  (cmd.wr_data == fpp_pkg::CMD_EVFY);
                  cmd.op       <= (cmd.wr_data == fpp_pkg::CMD_PVFY) ? fpp_pkg::FPP_OP_PVFY :
                                  (cmd.wr_data == fpp_pkg::CMD_EVFY) ? fpp_pkg::FPP_OP_EVFY :
                                  fpp_pkg::FPP_OP_READ;
               end
            endcase
         end
      end
   end
endmodule

// *** hw/fpp_strobe_capture.sv ***
// module: write strobe edge capture of address and data
module fpp_strobe_capture (
   input  wire logic                       clock,
   input  wire logic                       reset,
   input  wire logic                       write_active,
   input  wire logic                       we_n,
   input  wire logic [fpp_pkg::ADDR_W-1:0] addr,
   input  wire logic [fpp_pkg::DATA_W-1:0] data_in,
   fpp_cmd_if.capture                      cap
);
   logic                       we_n_q;
   logic                       armed_q;
   logic [fpp_pkg::ADDR_W-1:0] addr_q;

   assign cap.wr_addr = addr_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         we_n_q <= 1'b1;
      end else begin
         we_n_q <= we_n;
      end
   end

   // address at every falling strobe edge; armed only while writes are allowed
   always_ff @(posedge clock) begin
      if (reset) begin
         armed_q <= 1'b0;
         addr_q  <= fpp_pkg::ADDR_RESET;
      end else if (we_n_q && !we_n) begin
         armed_q <= write_active;
         addr_q  <= addr;
      end else if (!we_n_q && we_n) begin
         armed_q <= 1'b0;
      end
   end

   // command or data byte at the rising strobe edge
   always_ff @(posedge clock) begin
      if (reset) begin
         cap.wr_valid <= 1'b0;
         cap.wr_data  <= '0;
      end else begin
         cap.wr_valid <= !we_n_q && we_n && armed_q;
         if (!we_n_q && we_n) begin
            cap.wr_data <= data_in;
         end
      end
   end
endmodule

// *** hw/fpp_port.sv ***
// top module: parallel programming port of the on-chip flash
module fpp_port (
   input  wire logic                       clock,
   input  wire logic                       reset,
   input  wire logic                       ce_n,
   input  wire logic                       oe_n,
   input  wire logic                       we_n,
   input  wire logic                       rw_mode_select,
   input  wire logic                       program_voltage_pin,
   input  wire logic [fpp_pkg::ADDR_W-1:0] addr,
   input  wire logic [fpp_pkg::DATA_W-1:0] data_in,
   output logic      [fpp_pkg::DATA_W-1:0] data_out,
   output logic                            data_oe,
   input  wire logic [fpp_pkg::DATA_W-1:0] array_rdata,
   output logic      [fpp_pkg::ADDR_W-1:0] array_addr,
   output logic                            op_valid,
   output fpp_pkg::fpp_op_e                op_code,
   output logic      [fpp_pkg::ADDR_W-1:0] op_addr,
   output logic      [fpp_pkg::DATA_W-1:0] op_data,
   output logic      [1:0]                 bus_state
);
   fpp_pkg::fpp_bus_e bus_d;
   logic              write_active;

   fpp_cmd_if cmd ();

   // pin level decode; any unlisted combination falls to standby
   always_comb begin
      bus_d = fpp_pkg::FPP_BUS_STANDBY;
      if (program_voltage_pin && !ce_n) begin
         if (!oe_n && we_n) begin
            bus_d = fpp_pkg::FPP_BUS_READ;
         end else if (oe_n && we_n) begin
            bus_d = fpp_pkg::FPP_BUS_OUT_DIS;
         end else if (oe_n && !we_n && rw_mode_select) begin
            bus_d = fpp_pkg::FPP_BUS_WRITE;
         end
      end
   end

   // read-only mode never reaches the write state, so its strobes are dropped
   assign write_active = (bus_d == fpp_pkg::FPP_BUS_WRITE);

   fpp_strobe_capture u_capture (
      .clock        (clock),
      .reset        (reset),
      .write_active (write_active),
      .we_n         (we_n),
      .addr         (addr),
      .data_in      (data_in),
      .cap          (cmd.capture)
   );

   fpp_cmd_decode u_decode (
      .clock (clock),
      .reset (reset),
      .cmd   (cmd.decode)
   );

   always_ff @(posedge clock) begin
      if (reset) begin
         bus_state <= 2'(fpp_pkg::FPP_BUS_STANDBY);
      end else begin
         bus_state <= 2'(bus_d);
      end
   end

   // drive only in the read state; no identification code path exists
   always_ff @(posedge clock) begin
      if (reset) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= (bus_d == fpp_pkg::FPP_BUS_READ);
      end
   end

   // array contents only after reset or once a read, verify or reset-pair command is in force
   always_ff @(posedge clock) begin
      if (reset) begin
         data_out <= fpp_pkg::IDLE_DATA;
      end else if (cmd.array_sel) begin
         data_out <= array_rdata;
      end else begin
         data_out <= fpp_pkg::IDLE_DATA;
      end
   end

   // full address incl. A16 goes to the array; A17 is never present
   always_ff @(posedge clock) begin
      if (reset) begin
         array_addr <= fpp_pkg::ADDR_RESET;
      end else begin
         array_addr <= addr;
      end
   end

   // user and boot areas are both passed to the controller, which sizes boot erase
   always_ff @(posedge clock) begin
      if (reset) begin
         op_valid <= 1'b0;
         op_code  <= fpp_pkg::FPP_OP_NONE;
         op_addr  <= fpp_pkg::ADDR_RESET;
         op_data  <= '0;
      end else begin
         op_valid <= cmd.op_valid;
         op_code  <= cmd.op;
         op_addr  <= cmd.op_addr;
         op_data  <= cmd.op_data;
      end
   end
endmodule

// *** verification/fpp_port_sva.sv ***
// checker: bus state and command timing seen at the port pins
module fpp_port_sva (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        ce_n,
   input wire logic        oe_n,
   input wire logic        we_n,
   input wire logic        rw_mode_select,
   input wire logic        program_voltage_pin,
   input wire logic [16:0] addr,
   input wire logic        data_oe,
   input wire logic [16:0] array_addr,
   input wire logic        op_valid,
   input wire logic [1:0]  bus_state
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rst_q, sb_q, rd_q, od_q, wr_q;
   // pin states one edge back, since the decoded state answers a cycle late
   always_ff @(posedge clock) begin
      rst_q <= reset;
      sb_q  <= ce_n || !program_voltage_pin;
      rd_q  <= !ce_n && !oe_n && we_n && program_voltage_pin;
      od_q  <= !ce_n && oe_n && we_n && program_voltage_pin;
      wr_q  <= !ce_n && oe_n && !we_n && rw_mode_select && program_voltage_pin;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   standby_float_a: assert property (
      !rst_q && sb_q |-> !data_oe && bus_state == 2'h0)
      else $error("data lines driven in standby");
   read_drive_a: assert property (!rst_q && rd_q |-> data_oe && bus_state == 2'h2)
      else $error("read state not driving");
   out_dis_a: assert property (!rst_q && od_q |-> !data_oe && bus_state == 2'h1)
      else $error("output disable not floating");
   write_state_a: assert property (!rst_q && wr_q |-> !data_oe && bus_state == 2'h3)
      else $error("write state not decoded");
   undef_float_a: assert property (!rd_q |-> !data_oe)
      else $error("data lines driven outside read");
   op_pulse_a: assert property (op_valid |=> !op_valid)
      else $error("operation strobe longer than one cycle");
   ro_ignore_a: assert property (op_valid |-> $past(rw_mode_select, 4))
      else $error("operation accepted in read-only mode");
   reset_vals_a: assert property (rst_q |-> !data_oe && !op_valid && bus_state == 2'h0)
      else $error("outputs wrong after reset");
   array_addr_a: assert property (!rst_q |-> array_addr == $past(addr))
      else $error("array address not following pins");
endmodule
bind fpp_port fpp_port_sva u_sva (.*);

// *** verification/fpp_prog_model.sv ***
// partner: programmer that drives the port pins
module fpp_prog_model (
   input  wire logic        clock,
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic             rw_mode_select,
   output logic             program_voltage_pin,
   output logic [16:0]      addr,
   output logic [7:0]       data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      rw_mode_select = 1'b1;
      program_voltage_pin = 1'b1;
      addr = 17'h00000;
      data_in = 8'h00;
   end
   task automatic pins(input logic c, input logic o, input logic w, input logic [16:0] a);
      @(posedge clock);
      ce_n <= c;
      oe_n <= o;
      we_n <= w;
      addr <= a;
   endtask
   task automatic mode(input logic rw, input logic vpp);
      @(posedge clock);
      rw_mode_select <= rw;
      program_voltage_pin <= vpp;
   endtask
   // one command or data byte; byte held across the strobe rise
   task automatic wr(input logic [16:0] a, input logic [7:0] d);
      pins(1'b0, 1'b1, 1'b0, a);
      data_in <= d;
      @(posedge clock);
      pins(1'b0, 1'b1, 1'b1, a);
      @(posedge clock);
      ce_n <= 1'b1;
      // released lines must not keep showing the byte
      data_in <= ~d;
      repeat (4) @(posedge clock);
   endtask
endmodule

// *** verification/fpp_port_tb.sv ***
// testbench: pin-level scenarios for the parallel programming port
module fpp_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clock = 1'b0;
   logic             reset = 1'b1;
   logic             ce_n, oe_n, we_n, rw_mode_select, program_voltage_pin;
   logic             data_oe, op_valid;
   logic [16:0]      addr, array_addr, op_addr, last_addr;
   logic [7:0]       data_in, data_out, array_rdata, op_data, last_data;
   logic [1:0]       bus_state;
   fpp_pkg::fpp_op_e op_code, last_op;
   int               errors = 0;
   int               checks = 0;
   int               n_op = 0;
   always #5 clock = ~clock;
   // array model: each byte is a pattern of its address
   assign array_rdata = array_addr[7:0] ^ 8'h5a;
   fpp_prog_model u_prog (.clock(clock), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .rw_mode_select(rw_mode_select), .program_voltage_pin(program_voltage_pin),
      .addr(addr), .data_in(data_in));
   fpp_port u_dut (.clock(clock), .reset(reset), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .rw_mode_select(rw_mode_select), .program_voltage_pin(program_voltage_pin),
      .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .array_rdata(array_rdata), .array_addr(array_addr), .op_valid(op_valid),
      .op_code(op_code), .op_addr(op_addr), .op_data(op_data), .bus_state(bus_state));
   always @(posedge clock) begin
      if (op_valid === 1'b1) begin
         n_op <= n_op + 1;
         last_op <= op_code;
         last_addr <= op_addr;
         last_data <= op_data;
      end
   end
   task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic rd_chk(input logic [16:0] a, input logic [7:0] exp);
      u_prog.pins(1'b0, 1'b0, 1'b1, a);
      repeat (3) @(posedge clock);
      #1 chk("read data", 17'(data_out), 17'(exp));
      u_prog.pins(1'b1, 1'b1, 1'b1, a);
   endtask
   task automatic t_reset;
      #1 chk("oe after reset", 17'(data_oe), 17'h0);
      chk("state after reset", 17'(bus_state), 17'h0);
      rd_chk(17'h100a3, 8'ha3 ^ 8'h5a);
      $display("test reset done");
   endtask
   task automatic t_bus;
      logic [5:0] row[8] = '{6'h0b, 6'h0f, 6'h1a, 6'h1e, 6'h2e, 6'h32, 6'h0c, 6'h06};
      logic [1:0] st[8] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
      for (int i = 0; i < 8; i++) begin
         u_prog.mode(row[i][2], row[i][1]);
         u_prog.pins(row[i][5], row[i][4], row[i][3], 17'h000c4);
         repeat (3) @(posedge clock);
         #1 chk("data_oe", 17'(data_oe), 17'(row[i][0]));
         chk("bus_state", 17'(bus_state), 17'(st[i]));
      end
      u_prog.pins(1'b1, 1'b1, 1'b1, 17'h00000);
      u_prog.mode(1'b1, 1'b1);
      $display("test bus states done");
   endtask
   task automatic t_cmds;
      logic [7:0] c1[6] = '{8'h40, 8'h20, 8'hff, 8'h00, 8'hc0, 8'ha0};
      logic [7:0] c2[6] = '{8'h3c, 8'h20, 8'hff, 8'h00, 8'h00, 8'h00};
      fpp_pkg::fpp_op_e ops[6] = '{fpp_pkg::FPP_OP_PROG, fpp_pkg::FPP_OP_ERASE,
         fpp_pkg::FPP_OP_RESET, fpp_pkg::FPP_OP_READ, fpp_pkg::FPP_OP_PVFY, fpp_pkg::FPP_OP_EVFY};
      int n0;
      for (int i = 0; i < 6; i++) begin
         n0 = n_op;
         u_prog.wr(17'h00000, c1[i]);
         if (i < 3) u_prog.wr(17'h10f0f, c2[i]);
         chk("op count", 17'(n_op - n0), 17'h1);
         chk("op code", 17'(last_op), 17'(ops[i]));
         if (i < 3) chk("op addr", last_addr, 17'h10f0f);
         if (i == 0) chk("op data", 17'(last_data), 17'h0003c);
      end
      rd_chk(17'h00011, 8'h11 ^ 8'h5a);
      $display("test commands done");
   endtask
   task automatic t_guard;
      int n0;
      n0 = n_op;
      u_prog.mode(1'b0, 1'b1);
      u_prog.wr(17'h00000, 8'h20);
      u_prog.wr(17'h00000, 8'h20);
      chk("read-only ops", 17'(n_op - n0), 17'h0);
      u_prog.mode(1'b1, 1'b1);
      // erase opener followed by a foreign byte must fall back without an operation
      u_prog.wr(17'h00000, 8'h20);
      u_prog.wr(17'h00000, 8'h55);
      chk("erase mismatch ops", 17'(n_op - n0), 17'h0);
      u_prog.wr(17'h00000, 8'h55);
      rd_chk(17'h00022, 8'hff);
      u_prog.wr(17'h00000, 8'h00);
      rd_chk(17'h00022, 8'h22 ^ 8'h5a);
      // a reset in mid-run must bring back read mode after an unknown byte
      u_prog.wr(17'h00000, 8'h55);
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rd_chk(17'h00033, 8'h33 ^ 8'h5a);
      $display("test guards done");
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      $display("ERROR watchdog expected done seen hang");
      close_out();
   end
   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_reset();
      t_bus();
      t_cmds();
      t_guard();
      close_out();
   end
endmodule
